// *** rtl/fcs_pkg.sv ***
package fcs_pkg;

  // Register map on the plain register port
  localparam logic [15:0] FCS_OFS_DIVIDER = 16'h1820;
  localparam logic [15:0] FCS_OFS_STATUS = 16'h1825;
  localparam logic [15:0] FCS_OFS_COMMAND = 16'h1826;
  localparam logic [15:0] FCS_ARRAY_BASE = 16'hE000;

  // Status field positions
  localparam int FCS_BIT_CBEF = 7;
  localparam int FCS_BIT_CCF = 6;
  localparam int FCS_BIT_PVIOL = 5;
  localparam int FCS_BIT_ACCERR = 4;
  localparam int FCS_BIT_BLANK = 2;

  // Reset values
  localparam logic [7:0] FCS_STATUS_RESET = 8'hC0;
  localparam logic [7:0] FCS_COMMAND_RESET = 8'h00;
  localparam logic [1:0] FCS_SEC_RESET = 2'h0;
  localparam logic [1:0] FCS_SEC_UNSECURED = 2'h2;

  // Page of 512 bytes: address bits from this index upward select the page
  localparam int FCS_PAGE_LSB = 9;

  typedef enum logic [7:0] {
    FCS_CMD_BLANK = 8'h05,
    FCS_CMD_BYTE = 8'h20,
    FCS_CMD_BURST = 8'h25,
    FCS_CMD_PAGE = 8'h40,
    FCS_CMD_MASS = 8'h41
  } fcs_cmd_type;

  typedef enum logic [2:0] {
    FCS_SEQ_IDLE = 3'b001,
    FCS_SEQ_DATA = 3'b010,
    FCS_SEQ_CMD = 3'b100
  } fcs_seq_type;

  // One command towards the array
  typedef struct packed {
    logic start;
    logic abort;
    fcs_cmd_type code;
    logic [15:0] addr;
    logic [7:0] data;
  } fcs_arr_req_type;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fcs_bus_req_type;

endpackage

// *** rtl/fcs_top.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Status bits 3, 1, 0 read zero, ignore writes; other bits always readable.
// - Buffer-empty flag clears on writing one (launch); sets again on hand-off to the array.
// - Only burst program commands are buffered; flag zero means buffer full.
// - Complete flag sets when buffer empty and idle; clears on launch; not writable.
// - Protection flag sets on launch hitting protected location; command discarded.
// - Protection flag clears only when software writes one to it.
// - Access error flag sets on any command sequence departure; command discarded.
// - Program or erase before divider written since reset gives access error.
// - Entering stop while a command is in progress gives access error.
// - Access error clears on writing one; writing zero leaves it.
// - Blank flag sets at blank check end only if whole array erased.
// - Blank flag clears on a new valid launch; direct writes ignored.
// - Command register recognises five codes; blank check 0x05, byte program 0x20.
// - Code 0x25 is burst byte program, the only bufferable command.
// - Code 0x40 erases the 512-byte page holding the address.
// - Code 0x41 erases the whole array.
// - Any other code is illegal and sets the access error flag.
// - Successful blank check sets the security code to unsecured 1:0.
// - Protected locations are never programmed or erased.
module fcs_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire fcs_pkg::fcs_bus_req_type bus_i,
  output logic [7:0] rdata_o,
  input wire logic stop_req_i,
  input wire logic prot_disable_i,
  input wire logic [6:0] prot_select_i,
  input wire logic [1:0] nv_security_i,
  input wire logic arr_done_i,
  input wire logic arr_blank_i,
  output fcs_pkg::fcs_arr_req_type arr_req_o,
  output logic [1:0] security_state_code_o
);
  import fcs_pkg::*;

  typedef struct packed {
    fcs_seq_type seq;
    logic cbef;
    logic ccf;
    logic pviol;
    logic accerr;
    logic blank;
    logic busy;
    logic div_written;
    logic sec_loaded;
    logic [1:0] sec;
    fcs_cmd_type cur_code;
    fcs_cmd_type buf_code;
    logic [15:0] buf_addr;
    logic [7:0] buf_data;
    fcs_cmd_type cmd_code;
    logic [15:0] seq_addr;
    logic [7:0] seq_data;
    fcs_arr_req_type arr;
    logic [7:0] rdata;
  } fcs_state_type;

  fcs_state_type st_r;
  fcs_state_type st_nxt;

  logic wr_stat;
  logic wr_cmd;
  logic wr_div;
  logic wr_arr;
  logic legal_code;
  logic is_prog_erase;
  logic protected_hit;
  logic busy_allows;
  logic [7:0] status_view;

  assign wr_stat = bus_i.wr && (bus_i.addr == FCS_OFS_STATUS);
  assign wr_cmd = bus_i.wr && (bus_i.addr == FCS_OFS_COMMAND);
  assign wr_div = bus_i.wr && (bus_i.addr == FCS_OFS_DIVIDER);
  assign wr_arr = bus_i.wr && (bus_i.addr >= FCS_ARRAY_BASE);

  always_comb begin
    case (bus_i.wdata)
      FCS_CMD_BLANK, FCS_CMD_BYTE, FCS_CMD_BURST,
      FCS_CMD_PAGE, FCS_CMD_MASS: legal_code = 1'b1;
      default: legal_code = 1'b0;
    endcase
  end

  assign is_prog_erase = (st_r.cmd_code != FCS_CMD_BLANK);

  // Mass erase touches every page, so any protected block refuses it
  always_comb begin
    protected_hit = 1'b0;
    if (!prot_disable_i && is_prog_erase) begin
      if (st_r.cmd_code == FCS_CMD_MASS) begin
        protected_hit = 1'b1;
      end else if (st_r.seq_addr[15:FCS_PAGE_LSB] >= prot_select_i) begin
        protected_hit = 1'b1;
      end
    end
  end

  // A busy array accepts only a burst behind a burst
  assign busy_allows = !st_r.busy ||
    ((st_r.cur_code == FCS_CMD_BURST) && (st_r.cmd_code == FCS_CMD_BURST));

  always_comb begin
    status_view = 8'h00;
    status_view[FCS_BIT_CBEF] = st_r.cbef;
    status_view[FCS_BIT_CCF] = st_r.ccf;
    status_view[FCS_BIT_PVIOL] = st_r.pviol;
    status_view[FCS_BIT_ACCERR] = st_r.accerr;
    status_view[FCS_BIT_BLANK] = st_r.blank;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.arr.start = 1'b0;
    st_nxt.arr.abort = 1'b0;
    st_nxt.rdata = 8'h00;

    // Security code is taken from nonvolatile options once after reset
    if (!st_r.sec_loaded) begin
      st_nxt.sec = nv_security_i;
      st_nxt.sec_loaded = 1'b1;
    end

    // Software clears go first so that a same-cycle hardware set wins
    if (wr_stat && bus_i.wdata[FCS_BIT_PVIOL]) begin
      st_nxt.pviol = 1'b0;
    end
    if (wr_stat && bus_i.wdata[FCS_BIT_ACCERR]) begin
      st_nxt.accerr = 1'b0;
    end

    if (st_r.busy && arr_done_i) begin
      st_nxt.busy = 1'b0;
      if ((st_r.cur_code == FCS_CMD_BLANK) && arr_blank_i) begin
        st_nxt.blank = 1'b1;
        st_nxt.sec = FCS_SEC_UNSECURED;
      end
    end

    // Buffered command goes to the array as soon as it is free
    if (!st_r.cbef && !st_nxt.busy) begin
      st_nxt.arr.start = 1'b1;
      st_nxt.arr.code = st_r.buf_code;
      st_nxt.arr.addr = st_r.buf_addr;
      st_nxt.arr.data = st_r.buf_data;
      st_nxt.cur_code = st_r.buf_code;
      st_nxt.busy = 1'b1;
      st_nxt.cbef = 1'b1;
    end

    if (wr_div) begin
      st_nxt.div_written = 1'b1;
    end

    if (wr_arr) begin
      if ((st_r.seq == FCS_SEQ_IDLE) && st_r.cbef) begin
        st_nxt.seq_addr = bus_i.addr;
        st_nxt.seq_data = bus_i.wdata;
        st_nxt.seq = FCS_SEQ_DATA;
      end else begin
        st_nxt.accerr = 1'b1;
        st_nxt.seq = FCS_SEQ_IDLE;
      end
    end

    if (wr_cmd) begin
      if ((st_r.seq == FCS_SEQ_DATA) && legal_code) begin
        st_nxt.cmd_code = fcs_cmd_type'(bus_i.wdata);
        st_nxt.seq = FCS_SEQ_CMD;
      end else begin
        st_nxt.accerr = 1'b1;
        st_nxt.seq = FCS_SEQ_IDLE;
      end
    end

    if (wr_stat && bus_i.wdata[FCS_BIT_CBEF]) begin
      st_nxt.seq = FCS_SEQ_IDLE;
      if ((st_r.seq != FCS_SEQ_CMD) || !st_r.cbef) begin
        st_nxt.accerr = 1'b1;
      end else if (is_prog_erase && !st_r.div_written) begin
        st_nxt.accerr = 1'b1;
      end else if (!busy_allows) begin
        st_nxt.accerr = 1'b1;
      end else if (protected_hit) begin
        st_nxt.pviol = 1'b1;
      end else begin
        st_nxt.buf_code = st_r.cmd_code;
        st_nxt.buf_addr = st_r.seq_addr;
        st_nxt.buf_data = st_r.seq_data;
        st_nxt.cbef = 1'b0;
        st_nxt.blank = 1'b0;
      end
    end

    // Stop kills the running and the buffered command alike
    if (stop_req_i && (st_r.busy || !st_r.cbef)) begin
      st_nxt.accerr = 1'b1;
      st_nxt.arr.abort = 1'b1;
      st_nxt.arr.start = 1'b0;
      st_nxt.busy = 1'b0;
      st_nxt.cbef = 1'b1;
    end

    st_nxt.ccf = st_nxt.cbef && !st_nxt.busy;

    if (bus_i.rd) begin
      if (bus_i.addr == FCS_OFS_STATUS) begin
        st_nxt.rdata = status_view;
      end else begin
        st_nxt.rdata = FCS_COMMAND_RESET;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
      st_r.seq <= FCS_SEQ_IDLE;
      st_r.cbef <= FCS_STATUS_RESET[FCS_BIT_CBEF];
      st_r.ccf <= FCS_STATUS_RESET[FCS_BIT_CCF];
      st_r.sec <= FCS_SEC_RESET;
      st_r.cur_code <= FCS_CMD_BLANK;
      st_r.buf_code <= FCS_CMD_BLANK;
      st_r.cmd_code <= FCS_CMD_BLANK;
      st_r.arr.code <= FCS_CMD_BLANK;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign arr_req_o = st_r.arr;
  assign security_state_code_o = st_r.sec;

  property p_reserved_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
    $past(bus_i.rd) && ($past(bus_i.addr) == FCS_OFS_STATUS) |->
      (rdata_o[3] == 1'b0) && (rdata_o[1:0] == 2'b00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_cmd_reads_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
    bus_i.rd && (bus_i.addr == FCS_OFS_COMMAND) |=> rdata_o == 8'h00;
  endproperty
  a_cmd_reads_zero: assert property (p_cmd_reads_zero) else $error("command read nonzero");

  property p_handoff;
    @(posedge clk_i) disable iff (!reset_n_i)
    arr_req_o.start |-> st_r.cbef && st_r.busy && !$past(st_r.cbef);
  endproperty
  a_handoff: assert property (p_handoff) else $error("hand-off left buffer full");

  property p_ccf_meaning;
    @(posedge clk_i) disable iff (!reset_n_i)
    st_r.ccf == (st_r.cbef && !st_r.busy);
  endproperty
  a_ccf_meaning: assert property (p_ccf_meaning) else $error("complete flag wrong");

  property p_pviol_sticky;
    @(posedge clk_i) disable iff (!reset_n_i)
    st_r.pviol && !(wr_stat && bus_i.wdata[FCS_BIT_PVIOL]) |=> st_r.pviol;
  endproperty
  a_pviol_sticky: assert property (p_pviol_sticky) else $error("pviol lost");

  property p_accerr_sticky;
    @(posedge clk_i) disable iff (!reset_n_i)
    st_r.accerr && !(wr_stat && bus_i.wdata[FCS_BIT_ACCERR]) |=> st_r.accerr;
  endproperty
  a_accerr_sticky: assert property (p_accerr_sticky) else $error("accerr lost");

  property p_illegal_code;
    @(posedge clk_i) disable iff (!reset_n_i)
    wr_cmd && !legal_code |=> st_r.accerr && (st_r.seq == FCS_SEQ_IDLE);
  endproperty
  a_illegal_code: assert property (p_illegal_code) else $error("illegal code accepted");

  property p_stop_error;
    @(posedge clk_i) disable iff (!reset_n_i)
    stop_req_i && st_r.busy |=> st_r.accerr && arr_req_o.abort && !st_r.busy;
  endproperty
  a_stop_error: assert property (p_stop_error) else $error("stop not flagged");

  property p_no_div;
    @(posedge clk_i) disable iff (!reset_n_i)
    !st_r.div_written && !wr_div |-> !(arr_req_o.start && arr_req_o.code != FCS_CMD_BLANK);
  endproperty
  a_no_div: assert property (p_no_div) else $error("array used before divider");

  property p_blank_unsec;
    @(posedge clk_i) disable iff (!reset_n_i)
    st_r.busy && arr_done_i && arr_blank_i && (st_r.cur_code == FCS_CMD_BLANK) |=>
      st_r.blank && (security_state_code_o == FCS_SEC_UNSECURED);
  endproperty
  a_blank_unsec: assert property (p_blank_unsec) else $error("blank result lost");

  property p_launch_clears_blank;
    @(posedge clk_i) disable iff (!reset_n_i)
    // A stop in the buffered cycle aborts instead of starting
    $fell(st_r.cbef) |-> !st_r.blank && !st_r.ccf ##1
      (arr_req_o.start || arr_req_o.abort || st_r.busy);
  endproperty
  a_launch_clears_blank: assert property (p_launch_clears_blank) else $error("launch");

  property p_reset_idle;
    @(posedge clk_i) !reset_n_i |=> st_r.cbef && st_r.ccf && !st_r.pviol && !st_r.accerr;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("reset state wrong");

  // A launch that passed the sequence checks; the later checks decide its fate
  logic launch_try;
  assign launch_try = wr_stat && bus_i.wdata[FCS_BIT_CBEF] && (st_r.seq == FCS_SEQ_CMD) &&
    st_r.cbef;

  property p_launch_clean;
    @(posedge clk_i) disable iff (!reset_n_i)
    launch_try && !st_r.busy && st_r.div_written && !protected_hit |=>
      !st_r.cbef && !st_r.blank && !st_r.ccf;
  endproperty
  a_launch_clean: assert property (p_launch_clean) else $error("launch refused");

  property p_seq_launch_error;
    @(posedge clk_i) disable iff (!reset_n_i)
    wr_stat && bus_i.wdata[FCS_BIT_CBEF] && (st_r.seq != FCS_SEQ_CMD) |=> st_r.accerr;
  endproperty
  a_seq_launch_error: assert property (p_seq_launch_error) else $error("bad launch");

  property p_pviol_discard;
    @(posedge clk_i) disable iff (!reset_n_i)
    launch_try && !st_r.busy && st_r.div_written && protected_hit |=>
      st_r.pviol && st_r.cbef ##1 !arr_req_o.start;
  endproperty
  a_pviol_discard: assert property (p_pviol_discard) else $error("protected run");

  property p_no_div_launch;
    @(posedge clk_i) disable iff (!reset_n_i)
    launch_try && !st_r.div_written && (st_r.cmd_code != FCS_CMD_BLANK) |=>
      st_r.accerr && st_r.cbef;
  endproperty
  a_no_div_launch: assert property (p_no_div_launch) else $error("no divider");

  property p_busy_refuse;
    @(posedge clk_i) disable iff (!reset_n_i)
    launch_try && st_r.busy &&
      ((st_r.cur_code != FCS_CMD_BURST) || (st_r.cmd_code != FCS_CMD_BURST)) |=>
      st_r.accerr;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("non-burst buffered");

  property p_burst_handoff;
    @(posedge clk_i) disable iff (!reset_n_i)
    !st_r.cbef && st_r.busy && arr_done_i && !stop_req_i |=>
      arr_req_o.start && (arr_req_o.code == FCS_CMD_BURST);
  endproperty
  a_burst_handoff: assert property (p_burst_handoff) else $error("burst lost");

  property p_blank_no_write;
    @(posedge clk_i) disable iff (!reset_n_i)
    !st_r.blank && !(st_r.busy && arr_done_i) |=> !st_r.blank;
  endproperty
  a_blank_no_write: assert property (p_blank_no_write) else $error("blank set");

  property p_sec_stable;
    @(posedge clk_i) disable iff (!reset_n_i)
    st_r.sec_loaded && !(st_r.busy && arr_done_i && arr_blank_i) |=>
      $stable(security_state_code_o);
  endproperty
  a_sec_stable: assert property (p_sec_stable) else $error("security code moved");

  property p_stop_buffered;
    @(posedge clk_i) disable iff (!reset_n_i)
    stop_req_i && !st_r.cbef |=> st_r.cbef && st_r.accerr && !arr_req_o.start;
  endproperty
  a_stop_buffered: assert property (p_stop_buffered) else $error("stop kept buffer");

  c_burst_buffered: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    st_r.busy && !st_r.cbef && (st_r.buf_code == FCS_CMD_BURST));
  c_blank_pass: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(st_r.blank));
  c_pviol: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(st_r.pviol));
  c_stop_abort: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    arr_req_o.abort);

endmodule

// *** testbench/flash_command_status_unit_tb.sv ***
`timescale 1ns/1ps
module flash_command_status_unit_tb;
  import fcs_pkg::*;
  logic clk_i, reset_n_i, stop_req_i, prot_disable_i, arr_done_i, arr_blank_i;
  logic [6:0] prot_select_i;
  logic [1:0] nv_security_i, security_state_code_o;
  logic [7:0] rdata_o;
  fcs_bus_req_type bus_i;
  fcs_arr_req_type arr_req_o;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  int n_starts = 0;
  int n_aborts = 0;

  fcs_top i_fcs_top (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .stop_req_i(stop_req_i), .prot_disable_i(prot_disable_i), .prot_select_i(prot_select_i),
    .nv_security_i(nv_security_i), .arr_done_i(arr_done_i), .arr_blank_i(arr_blank_i),
    .arr_req_o(arr_req_o), .security_state_code_o(security_state_code_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Counting pulses lets a scenario prove that a refused command never reached the array
  always @(posedge clk_i) begin
    cycles++;
    if (arr_req_o.start === 1'b1) n_starts++;
    if (arr_req_o.abort === 1'b1) n_aborts++;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task put(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
  endtask

  task idle();
    @(posedge clk_i);
    bus_i <= '0;
    #1;
  endtask

  task get(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_i);
    bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    bus_i <= '0;
    #1;
    d = rdata_o;
  endtask

  task status_is(input logic [7:0] exp);
    logic [7:0] d;
    get(FCS_OFS_STATUS, d);
    check_val("status", {8'h00, exp}, {8'h00, d});
  endtask

  task clear_status(input logic [7:0] d);
    put(FCS_OFS_STATUS, d);
    idle();
  endtask

  task launch(input logic [7:0] code, input logic [15:0] a, input logic [7:0] d);
    put(a, d);
    put(FCS_OFS_COMMAND, code);
    put(FCS_OFS_STATUS, 8'h80);
    idle();
  endtask

  // Looks at the present cycle first, so a start right after a done pulse is not missed
  task wait_start(input logic [7:0] code, input logic [15:0] a, input logic [7:0] d);
    int i;
    for (i = 0; i < 20; i++) begin
      if (arr_req_o.start === 1'b1) break;
      @(posedge clk_i);
      #1;
    end
    check_val("start", 16'h0001, {15'h0000, arr_req_o.start});
    check_val("code", {8'h00, code}, {8'h00, arr_req_o.code});
    check_val("addr", a, arr_req_o.addr);
    check_val("data", {8'h00, d}, {8'h00, arr_req_o.data});
  endtask

  task finish_cmd(input logic blank);
    @(posedge clk_i);
    arr_done_i <= 1'b1;
    arr_blank_i <= blank;
    @(posedge clk_i);
    arr_done_i <= 1'b0;
    arr_blank_i <= 1'b0;
    #1;
  endtask

  task t_reset();
    logic [7:0] d;
    status_is(8'hC0);
    get(FCS_OFS_COMMAND, d);
    check_val("command", 16'h0000, {8'h00, d});
    get(16'h1000, d);
    check_val("unmapped", 16'h0000, {8'h00, d});
    check_val("security", 16'h0000, {14'h0000, security_state_code_o});
    clear_status(8'h0B);
    status_is(8'hC0);
  endtask

  task t_no_divider();
    launch(8'h20, 16'hE000, 8'h55);
    status_is(8'hD0);
    clear_status(8'h00);
    status_is(8'hD0);
    clear_status(8'h10);
    status_is(8'hC0);
  endtask

  task t_sequence();
    put(FCS_OFS_DIVIDER, 8'h13);
    idle();
    launch(8'h33, 16'hE000, 8'h01);
    status_is(8'hD0);
    clear_status(8'h10);
    put(FCS_OFS_COMMAND, 8'h20);
    put(FCS_OFS_STATUS, 8'h80);
    idle();
    status_is(8'hD0);
    clear_status(8'h10);
  endtask

  task t_codes();
    logic [7:0] codes [4];
    int i;
    codes = '{8'h20, 8'h25, 8'h40, 8'h41};
    for (i = 0; i < 4; i++) begin
      launch(codes[i], 16'hE200, 8'h3C);
      wait_start(codes[i], 16'hE200, 8'h3C);
      status_is(8'h80);
      finish_cmd(1'b0);
      status_is(8'hC0);
    end
    launch(8'h20, 16'hE000, 8'h66);
    wait_start(8'h20, 16'hE000, 8'h66);
    finish_cmd(1'b0);
    status_is(8'hC0);
  endtask

  task t_blank();
    launch(8'h05, 16'hE000, 8'hFF);
    wait_start(8'h05, 16'hE000, 8'hFF);
    finish_cmd(1'b1);
    status_is(8'hC4);
    check_val("security", 16'h0002, {14'h0000, security_state_code_o});
    launch(8'h20, 16'hE010, 8'h77);
    wait_start(8'h20, 16'hE010, 8'h77);
    status_is(8'h80);
    finish_cmd(1'b0);
    launch(8'h05, 16'hE000, 8'hFF);
    wait_start(8'h05, 16'hE000, 8'hFF);
    finish_cmd(1'b0);
    status_is(8'hC0);
  endtask

  task t_burst();
    launch(8'h25, 16'hE000, 8'h01);
    wait_start(8'h25, 16'hE000, 8'h01);
    launch(8'h25, 16'hE001, 8'h02);
    status_is(8'h00);
    finish_cmd(1'b0);
    wait_start(8'h25, 16'hE001, 8'h02);
    status_is(8'h80);
    finish_cmd(1'b0);
    status_is(8'hC0);
  endtask

  task t_protect();
    int s;
    @(posedge clk_i);
    prot_disable_i <= 1'b0;
    s = n_starts;
    launch(8'h40, 16'hE000, 8'h00);
    status_is(8'hE0);
    check_val("starts", 16'h0000, 16'(n_starts - s));
    clear_status(8'h00);
    status_is(8'hE0);
    clear_status(8'h20);
    status_is(8'hC0);
    @(posedge clk_i);
    prot_select_i <= 7'h78;
    launch(8'h20, 16'hE200, 8'h5A);
    wait_start(8'h20, 16'hE200, 8'h5A);
    finish_cmd(1'b0);
    status_is(8'hC0);
    @(posedge clk_i);
    prot_disable_i <= 1'b1;
    prot_select_i <= 7'h70;
  endtask

  task t_stop();
    int a;
    a = n_aborts;
    launch(8'h20, 16'hE000, 8'h11);
    wait_start(8'h20, 16'hE000, 8'h11);
    @(posedge clk_i);
    stop_req_i <= 1'b1;
    @(posedge clk_i);
    stop_req_i <= 1'b0;
    status_is(8'hD0);
    check_val("aborts", 16'h0001, 16'(n_aborts - a));
    clear_status(8'h10);
  endtask

  initial begin
    reset_n_i = 1'b0;
    bus_i = '0;
    stop_req_i = 1'b0;
    prot_disable_i = 1'b1;
    prot_select_i = 7'h70;
    nv_security_i = 2'h0;
    arr_done_i = 1'b0;
    arr_blank_i = 1'b0;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_no_divider();
    t_sequence();
    t_codes();
    t_blank();
    t_burst();
    t_protect();
    t_stop();
    report_and_stop();
  end
endmodule
